// ---- cmp_control.sv ----
// Our own choices: register access over APB and the register offsets.
module cmp_control
    import cmp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic raw_compare,
    output logic analog_enable,
    output logic [1:0] neg_route,
    output logic neg_grounded,
    output logic pos_route,
    output logic pos_grounded,
    output logic result_pin,
    output logic result_pin_oe,
    output logic event_trigger,
    output logic irq
);

    logic [15:0] control_reg;
    logic event_flag_reg;
    logic result_reg;
    logic result_prev_reg;
    logic event_trigger_reg;
    logic [IRQ_WIDTH-1:0] irq_status_reg;
    logic [IRQ_WIDTH-1:0] irq_mask_reg;
    logic [4:0] input_avail_reg;
    logic raw_sync;
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic rise_seen;
    logic fall_seen;
    logic edge_match;
    logic [IRQ_WIDTH-1:0] irq_set;
    logic [31:0] rdata_next;
    logic channel_enable_reg;
    logic channel_enable_next;
    logic result_pin_enable_reg;
    logic result_pin_enable_next;
    logic result_invert_reg;
    logic result_invert_next;
    logic [1:0] event_edge_select_reg;
    logic [1:0] event_edge_select_next;
    logic reference_select_reg;
    logic reference_select_next;
    logic [1:0] input_channel_select_reg;
    logic [1:0] input_channel_select_next;
    logic [4:0] input_avail_next;
    logic result_next;
    logic result_pin_reg;
    logic [1:0] neg_route_reg;
    logic neg_grounded_reg;
    logic pos_route_reg;
    logic pos_grounded_reg;
    logic [1:0] neg_route_next;
    logic neg_grounded_next;
    logic pos_route_next;
    logic pos_grounded_next;

    // ==========================================================
    // Pin input synchroniser.
    cmp_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(raw_compare),
        .sync_out(raw_sync)
    );

    // ==========================================================
    // Input selection.
    cmp_input_mux u_mux (
        .input_channel_select(input_channel_select_next),
        .reference_select(reference_select_next),
        .input_avail(input_avail_next),
        .neg_route(neg_route_next),
        .neg_grounded(neg_grounded_next),
        .pos_route(pos_route_next),
        .pos_grounded(pos_grounded_next)
    );

    // ==========================================================
    // Bus decode.
    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == CONTROL_OFFSET) || (addr == IRQ_STATUS_OFFSET) ||
                    (addr == IRQ_MASK_OFFSET) || (addr == INPUT_AVAIL_OFFSET);
    endfunction : is_mapped

    function automatic logic reg_write(input logic strobe, input logic [11:0] addr, input logic [11:0] offset);
        reg_write = strobe && (addr == offset);
    endfunction : reg_write

    assign addr_hit = is_mapped(paddr);
    assign wr_en = psel && penable && pwrite && addr_hit;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // ==========================================================
    // Control fields.
    always_comb begin
        channel_enable_next = channel_enable_reg;
        result_pin_enable_next = result_pin_enable_reg;
        result_invert_next = result_invert_reg;
        event_edge_select_next = event_edge_select_reg;
        reference_select_next = reference_select_reg;
        input_channel_select_next = input_channel_select_reg;
        if (reg_write(wr_en, paddr, CONTROL_OFFSET)) begin
            channel_enable_next = pwdata[CHANNEL_ENABLE_BIT];
            result_pin_enable_next = pwdata[RESULT_PIN_ENABLE_BIT];
            result_invert_next = pwdata[RESULT_INVERT_BIT];
            event_edge_select_next = pwdata[EVENT_EDGE_HI_BIT:EVENT_EDGE_LO_BIT];
            reference_select_next = pwdata[REFERENCE_SELECT_BIT];
            input_channel_select_next = pwdata[CHANNEL_SELECT_HI_BIT:CHANNEL_SELECT_LO_BIT];
        end
    end

    assign input_avail_next = reg_write(wr_en, paddr, INPUT_AVAIL_OFFSET) ? pwdata[4:0] : input_avail_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            channel_enable_reg <= CONTROL_RESET[CHANNEL_ENABLE_BIT];
        end else begin
            channel_enable_reg <= channel_enable_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_pin_enable_reg <= CONTROL_RESET[RESULT_PIN_ENABLE_BIT];
        end else begin
            result_pin_enable_reg <= result_pin_enable_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_invert_reg <= CONTROL_RESET[RESULT_INVERT_BIT];
        end else begin
            result_invert_reg <= result_invert_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            event_edge_select_reg <= CONTROL_RESET[EVENT_EDGE_HI_BIT:EVENT_EDGE_LO_BIT];
        end else begin
            event_edge_select_reg <= event_edge_select_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reference_select_reg <= CONTROL_RESET[REFERENCE_SELECT_BIT];
        end else begin
            reference_select_reg <= reference_select_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            input_channel_select_reg <= CONTROL_RESET[CHANNEL_SELECT_HI_BIT:CHANNEL_SELECT_LO_BIT];
        end else begin
            input_channel_select_reg <= input_channel_select_next;
        end
    end

    always_comb begin
        control_reg = 16'h0000;
        control_reg[CHANNEL_ENABLE_BIT] = channel_enable_reg;
        control_reg[RESULT_PIN_ENABLE_BIT] = result_pin_enable_reg;
        control_reg[RESULT_INVERT_BIT] = result_invert_reg;
        control_reg[EVENT_EDGE_HI_BIT:EVENT_EDGE_LO_BIT] = event_edge_select_reg;
        control_reg[REFERENCE_SELECT_BIT] = reference_select_reg;
        control_reg[CHANNEL_SELECT_HI_BIT:CHANNEL_SELECT_LO_BIT] = input_channel_select_reg;
        control_reg = control_reg & CONTROL_WRITE_MASK;
    end

    assign analog_enable = control_reg[CHANNEL_ENABLE_BIT];

    // ==========================================================
    // Registered input routing.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            neg_route_reg <= 2'h0;
            neg_grounded_reg <= 1'b0;
            pos_route_reg <= 1'b0;
            pos_grounded_reg <= 1'b0;
        end else begin
            neg_route_reg <= neg_route_next;
            neg_grounded_reg <= neg_grounded_next;
            pos_route_reg <= pos_route_next;
            pos_grounded_reg <= pos_grounded_next;
        end
    end

    assign neg_route = neg_route_reg;
    assign neg_grounded = neg_grounded_reg;
    assign pos_route = pos_route_reg;
    assign pos_grounded = pos_grounded_reg;

    // ==========================================================
    // Result path.
    assign result_next = channel_enable_reg && (raw_sync ^ result_invert_reg);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_reg <= 1'b0;
            result_prev_reg <= 1'b0;
            result_pin_reg <= 1'b0;
        end else begin
            result_reg <= result_next;
            result_prev_reg <= result_reg;
            result_pin_reg <= result_next && result_pin_enable_next;
        end
    end

    assign result_pin = result_pin_reg;
    assign result_pin_oe = control_reg[RESULT_PIN_ENABLE_BIT];

    // ==========================================================
    // Edge event detection.
    assign rise_seen = result_reg && !result_prev_reg;
    assign fall_seen = !result_reg && result_prev_reg;

    always_comb begin
        case (control_reg[EVENT_EDGE_HI_BIT:EVENT_EDGE_LO_BIT])
            EDGE_FALLING: edge_match = fall_seen;
            EDGE_RISING: edge_match = rise_seen;
            default: edge_match = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            event_flag_reg <= 1'b0;
        end else if (control_reg[CHANNEL_ENABLE_BIT] && edge_match && !event_flag_reg) begin
            event_flag_reg <= 1'b1;
        end else if (reg_write(wr_en, paddr, CONTROL_OFFSET) && !pwdata[EDGE_EVENT_FLAG_BIT]) begin
            event_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            event_trigger_reg <= 1'b0;
        end else begin
            event_trigger_reg <= control_reg[CHANNEL_ENABLE_BIT] && edge_match && !event_flag_reg;
        end
    end

    assign event_trigger = event_trigger_reg;

    // ==========================================================
    // Interrupt status and mask.
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_EVENT_BIT] = event_trigger_reg;
        irq_set[IRQ_RISE_BIT] = control_reg[CHANNEL_ENABLE_BIT] && rise_seen && !event_flag_reg;
        irq_set[IRQ_FALL_BIT] = control_reg[CHANNEL_ENABLE_BIT] && fall_seen && !event_flag_reg;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_status_reg <= IRQ_RESET;
        end else if (wr_en && paddr == IRQ_STATUS_OFFSET) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_WIDTH-1:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_mask_reg <= IRQ_RESET;
        end else if (wr_en && paddr == IRQ_MASK_OFFSET) begin
            irq_mask_reg <= pwdata[IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ==========================================================
    // Package input availability.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            input_avail_reg <= INPUT_AVAIL_RESET;
        end else begin
            input_avail_reg <= input_avail_next;
        end
    end

    // ==========================================================
    // Read data.
    always_comb begin
        rdata_next = 32'h00000000;
        case (paddr)
            CONTROL_OFFSET: begin
                rdata_next[15:0] = control_reg;
                rdata_next[EDGE_EVENT_FLAG_BIT] = event_flag_reg;
                rdata_next[COMPARE_RESULT_BIT] = result_reg;
            end
            IRQ_STATUS_OFFSET: begin
                rdata_next[IRQ_WIDTH-1:0] = irq_status_reg;
            end
            IRQ_MASK_OFFSET: begin
                rdata_next[IRQ_WIDTH-1:0] = irq_mask_reg;
            end
            INPUT_AVAIL_OFFSET: begin
                rdata_next[4:0] = input_avail_reg;
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= rdata_next;
        end
    end

endmodule : cmp_control

// ---- cmp_control_props.sv ----
module cmp_control_props
    import cmp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic analog_enable,
    input wire logic [1:0] neg_route,
    input wire logic neg_grounded,
    input wire logic pos_route,
    input wire logic pos_grounded,
    input wire logic result_pin,
    input wire logic result_pin_oe,
    input wire logic event_trigger,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic mapped;
    logic wr;
    assign mapped = paddr == CONTROL_OFFSET || paddr == IRQ_STATUS_OFFSET || paddr == IRQ_MASK_OFFSET
        || paddr == INPUT_AVAIL_OFFSET;
    assign wr = psel && penable && pwrite;
    a_pready_high: assert property (pready) else $error("pready low");
    a_slverr_map: assert property (psel && penable |-> pslverr == !mapped) else $error("pslverr wrong");
    a_read_refused: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_pin_gated: assert property (!result_pin_oe |-> !result_pin) else $error("pin driven");
    a_disabled_low: assert property ((!analog_enable) [*4] |-> !result_pin) else $error("off result");
    a_trigger_single: assert property (event_trigger |=> !event_trigger) else $error("trigger repeat");
    a_oe_by_write: assert property ($changed(result_pin_oe) |-> $past(wr && paddr == CONTROL_OFFSET))
        else $error("oe changed alone");
    a_enable_by_write: assert property ($changed(analog_enable) |-> $past(wr && paddr == CONTROL_OFFSET))
        else $error("enable changed alone");
    a_routes_by_write: assert property ($changed({neg_route, neg_grounded, pos_route, pos_grounded})
        |-> $past(wr)) else $error("route changed alone");
    a_reserved_zero: assert property (psel && penable && !pwrite && paddr == CONTROL_OFFSET |->
        prdata[12:10] == 3'h0 && prdata[5] == 1'b0 && prdata[3:2] == 2'h0) else $error("reserved bit set");
    c_trigger: cover property (event_trigger);
    c_irq: cover property ($rose(irq));
    c_refused: cover property (psel && penable && pslverr);
endmodule : cmp_control_props

// ---- cmp_core_model.sv ----
module cmp_core_model (
    input wire logic core_clk,
    input wire logic analog_enable,
    input wire logic pos_grounded,
    input wire logic neg_grounded,
    input wire logic [7:0] pos_level,
    input wire logic [7:0] neg_level,
    output logic raw_compare
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Analog core: a switched-off core gives a changing pattern.
    logic noise = 1'b0;
    logic [7:0] p;
    logic [7:0] n;
    always @(posedge core_clk) noise <= !noise;
    assign p = pos_grounded ? 8'h00 : pos_level;
    assign n = neg_grounded ? 8'h00 : neg_level;
    assign raw_compare = analog_enable ? (p > n) : noise;
endmodule : cmp_core_model

// ---- cmp_input_mux.sv ----
module cmp_input_mux
    import cmp_pkg::*;
(
    input wire logic [1:0] input_channel_select,
    input wire logic reference_select,
    input wire logic [4:0] input_avail,
    output logic [1:0] neg_route,
    output logic neg_grounded,
    output logic pos_route,
    output logic pos_grounded
);

    // ==========================================================
    // Input routing; a missing input is tied to ground.
    always_comb begin
        neg_route = input_channel_select;
        neg_grounded = !input_avail[input_channel_select];
        pos_route = reference_select;
        pos_grounded = !input_avail[{2'h1, reference_select}];
    end

endmodule : cmp_input_mux

// ---- cmp_pkg.sv ----
package cmp_pkg;

    // ==========================================================
    // Register map.
    localparam logic [11:0] CONTROL_OFFSET = 12'h000;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h008;
    localparam logic [11:0] INPUT_AVAIL_OFFSET = 12'h00C;

    // ==========================================================
    // Control register fields.
    localparam int CHANNEL_ENABLE_BIT = 15;
    localparam int RESULT_PIN_ENABLE_BIT = 14;
    localparam int RESULT_INVERT_BIT = 13;
    localparam int EDGE_EVENT_FLAG_BIT = 9;
    localparam int COMPARE_RESULT_BIT = 8;
    localparam int EVENT_EDGE_HI_BIT = 7;
    localparam int EVENT_EDGE_LO_BIT = 6;
    localparam int REFERENCE_SELECT_BIT = 4;
    localparam int CHANNEL_SELECT_HI_BIT = 1;
    localparam int CHANNEL_SELECT_LO_BIT = 0;
    localparam logic [15:0] CONTROL_WRITE_MASK = 16'hE0D3;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // ==========================================================
    // Event edge selection codes.
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_RISING = 2'h1;

    // ==========================================================
    // Interrupt status bits.
    localparam int IRQ_EVENT_BIT = 0;
    localparam int IRQ_RISE_BIT = 1;
    localparam int IRQ_FALL_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Input availability reset: every input present.
    localparam logic [4:0] INPUT_AVAIL_RESET = 5'h1F;

endpackage : cmp_pkg

// ---- cmp_sync.sv ----
module cmp_sync
    import cmp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic stage1_reg;
    logic stage2_reg;

    // ==========================================================
    // Two-flop synchroniser.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule : cmp_sync

// ---- tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cmp_pkg::*;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, trig_count = 32'h0, base = 32'h0;
    logic pready, pslverr, err, raw_compare, analog_enable, neg_grounded, pos_route, pos_grounded;
    logic result_pin, result_pin_oe, event_trigger, irq;
    logic [1:0] neg_route, code;
    logic [7:0] pos_level = 8'h01, neg_level = 8'h02;
    int miscompares = 0, checks = 0, cycles = 0;
    cmp_control cmp_control_inst (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .raw_compare, .analog_enable, .neg_route, .neg_grounded, .pos_route,
        .pos_grounded, .result_pin, .result_pin_oe, .event_trigger, .irq);
    cmp_core_model cmp_core_model_inst (.core_clk, .analog_enable, .pos_grounded, .neg_grounded,
        .pos_level, .neg_level, .raw_compare);
    // ==========================================================
    // Clock, trigger count and timeout.
    always #10 core_clk = !core_clk;
    always @(posedge core_clk) begin
        if (event_trigger === 1'b1) trig_count <= trig_count + 32'h1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            finish_test();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_eq
    task automatic set_raw(input logic v);
        pos_level <= v ? 8'h03 : 8'h01;
        repeat (8) @(posedge core_clk);
    endtask : set_raw
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // ==========================================================
    // Tests.
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(0, CONTROL_OFFSET, 0); check_eq(rd, 32'h0);
        apb(0, INPUT_AVAIL_OFFSET, 0); check_eq(rd, 32'h1F);
        apb(0, 12'h010, 0); check_eq({rd[31:1], err}, 32'h1);
        apb(1, CONTROL_OFFSET, 32'hFFFF); repeat (6) @(posedge core_clk);
        apb(0, CONTROL_OFFSET, 0); check_eq(rd, 32'hE1D3);
        check_eq({30'h0, result_pin_oe, result_pin}, 32'h3);
        check_eq({28'h0, analog_enable, neg_route, pos_route}, 32'hF);
        for (int i = 0; i < 2; i++) begin
            code = (i == 1) ? EDGE_FALLING : EDGE_RISING;
            set_raw(i == 1);
            apb(1, CONTROL_OFFSET, {16'h0, 8'h80, code, 6'h0}); repeat (8) @(posedge core_clk);
            base = trig_count;
            set_raw(i == 0); check_eq(trig_count - base, 32'h1);
            apb(0, CONTROL_OFFSET, 0); check_eq(rd, {16'h0, 7'h41, i == 0, code, 6'h0});
            set_raw(i == 1); set_raw(i == 0); check_eq(trig_count - base, 32'h1);
            apb(1, CONTROL_OFFSET, {16'h0, 8'h80, code, 6'h0});
            set_raw(i == 1); set_raw(i == 0); check_eq(trig_count - base, 32'h2);
        end
        apb(1, IRQ_MASK_OFFSET, 32'h1); @(posedge core_clk); check_eq(irq, 1);
        apb(1, IRQ_MASK_OFFSET, 32'h0); @(posedge core_clk); check_eq(irq, 0);
        apb(1, CONTROL_OFFSET, 32'h8080); apb(1, IRQ_STATUS_OFFSET, 32'h7);
        apb(1, IRQ_MASK_OFFSET, 32'h1); @(posedge core_clk); check_eq(irq, 0);
        apb(1, INPUT_AVAIL_OFFSET, 32'h0); apb(1, CONTROL_OFFSET, 32'h8000); @(posedge core_clk);
        check_eq({30'h0, neg_grounded, pos_grounded}, 32'h3);
        apb(1, INPUT_AVAIL_OFFSET, 32'h1F); @(posedge core_clk);
        check_eq({30'h0, neg_grounded, pos_grounded}, 32'h0);
        finish_test();
    end
endmodule : tb
bind cmp_control cmp_control_props cmp_control_props_inst (.core_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .analog_enable, .neg_route, .neg_grounded, .pos_route,
    .pos_grounded, .result_pin, .result_pin_oe, .event_trigger, .irq);
